// [arfa_defines.svh]
// register offsets, field positions, reset values and timing counts for the result formatter
`ifndef ARFA_DEFINES_SVH
`define ARFA_DEFINES_SVH

// register byte offsets on the apb slave
`define ARFA_OFF_CTRL_A       12'h000
`define ARFA_OFF_CTRL_B       12'h004
`define ARFA_OFF_CTRL_C       12'h008
`define ARFA_OFF_RESULT       12'h00C
`define ARFA_OFF_INT_FLAGS    12'h010
`define ARFA_OFF_INT_MASK     12'h014
`define ARFA_OFF_STATUS       12'h018

// control word a fields
`define ARFA_LEFT_ADJ_BIT     0
`define ARFA_DIFF_BIT         1
// control word b field
`define ARFA_ACC_LSB          0
`define ARFA_ACC_W            3
// control word c: start bit (self clearing)
`define ARFA_START_BIT        0
// interrupt flag bits
`define ARFA_IRQ_RESULT_READY_FLAG_BIT   0
`define ARFA_IRQ_OVR_BIT      1

// reset values
`define ARFA_CTRL_A_RST       2'h0
`define ARFA_CTRL_B_RST       3'h0
`define ARFA_RESULT_RST       16'h0000

// output formatting takes two peripheral clock cycles
`define ARFA_FORMAT_CYCLES    2

// single-ended and differential limits of the raw code
`define ARFA_SE_MAX           13'sh0FFF
`define ARFA_SE_MIN           13'sh0000
`define ARFA_DIFF_MAX         13'sh07FF
`define ARFA_DIFF_MIN         13'sh1800

// accumulations above this count get truncated
`define ARFA_TRUNC_LOG2       3'd4

`endif

// [arfa_pkg.sv]
// types shared by the result formatter files
package arfa_pkg;

  // raw sample from the analog core: wide signed code plus mode bit
  typedef struct packed {
    logic        valid;
    logic        diff;
    logic [12:0] code;
  } arfa_sample_s;

  // configuration steering the formatter
  typedef struct packed {
    logic       left_adjust_select;
    logic       diff;
    logic [2:0] accumulation_count_select;
  } arfa_cfg_s;

  typedef enum logic [1:0] {
    ARFA_IDLE,
    ARFA_ACCUM,
    ARFA_FORMAT
  } arfa_state_e;

endpackage : arfa_pkg

// [arfa_clamp.sv]
// clamps one raw conversion code into its legal range for the selected mode
`timescale 1ns/100ps
`include "arfa_defines.svh"

module arfa_clamp
  import arfa_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire arfa_pkg::arfa_sample_s raw_i,
  output logic        [11:0]        code_o,
  output logic                      valid_o
);

  ////////////////////////////////////////////////////////////////////////////
  // saturation of out-of-range inputs, registered for timing
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      code_o  <= 12'h000;
      valid_o <= 1'b0;
    end
    else
    begin
      valid_o <= raw_i.valid;
      if (raw_i.diff)
      begin
        // differential: signed range -2048..2047
        if ($signed(raw_i.code) > $signed(`ARFA_DIFF_MAX))
          code_o <= 12'h7FF;
        else if ($signed(raw_i.code) < $signed(`ARFA_DIFF_MIN))
          code_o <= 12'h800;
        else
          code_o <= raw_i.code[11:0];
      end
      else
      begin
        // single-ended: 2'b10 on the top bits means above reference, 2'b11 below ground,
        // so the core can report an over-reference input at all
        if (raw_i.code[12] && !raw_i.code[11])
          code_o <= 12'hFFF;
        else if (raw_i.code[12])
          code_o <= 12'h000;
        else
          code_o <= raw_i.code[11:0];
      end
    end
  end

endmodule : arfa_clamp

// [arfa_format.sv]
// turns an accumulated sum into the 16-bit result word (adjust, sign, truncate)
`timescale 1ns/100ps
`include "arfa_defines.svh"

module arfa_format
  import arfa_pkg::*;
(
  input  wire logic                mclk_i,
  input  wire logic                rst_n_i,
  input  wire logic                start_i,
  input  wire arfa_pkg::arfa_cfg_s cfg_i,
  input  wire logic        [18:0]  sum_i,
  output logic             [15:0]  word_o
);

  logic [18:0] shifted;   // sum after truncation of low bits
  logic [2:0]  width_add; // extra bits above 12 kept in the word
  logic [15:0] right_w;   // right-adjusted form
  logic [15:0] left_w;    // left-adjusted form

  ////////////////////////////////////////////////////////////////////////////
  // truncate above sixteen samples, then pick the adjust
  always_comb
  begin
    if (cfg_i.accumulation_count_select > `ARFA_TRUNC_LOG2)
    begin
      // keep the top 16 bits of the sum so nothing overflows
      shifted   = $signed(sum_i) >>> (cfg_i.accumulation_count_select - `ARFA_TRUNC_LOG2);
      width_add = `ARFA_TRUNC_LOG2;
    end
    else
    begin
      shifted   = sum_i;
      width_add = cfg_i.accumulation_count_select;
    end
    // sign bits fill the top for differential, zeros for single-ended
    right_w = shifted[15:0];
    // top value bit lands on bit 15, vacated low bits zero
    left_w  = shifted[15:0] << (3'd4 - width_add);
  end

  ////////////////////////////////////////////////////////////////////////////
  // result word captured once per finished sequence
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      word_o <= `ARFA_RESULT_RST;
    else if (start_i)
      word_o <= cfg_i.left_adjust_select ? left_w : right_w;
  end

endmodule : arfa_format

// [arfa_top.sv]
// result formatting and accumulation stage with apb registers and interrupt
//
// Summary of operation
// - single-ended over reference reads 4095
// - single-ended below ground reads zero
// - differential positive overrange saturates at 2047
// - differential negative overrange saturates at -2048
// - negative differential results are sign-extended
// - default result is right-adjusted
// - left-adjust bit puts msbs in high byte
// - sum consecutive samples per accumulation count
// - above sixteen samples truncate low bits
// - right-adjusted width grows per sample doubling
// - left-adjusted top bit at bit 15
// - single-ended unsigned, differential two's complement
// - completion updates result and sets ready flag
//
// Implementation choices: the address map and the APB slave port.
`timescale 1ns/100ps
`include "arfa_defines.svh"

module arfa_top
  import arfa_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  // apb slave
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [11:0] paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic      [31:0] prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  // analog core sample stream
  input  wire logic        sample_valid_i,
  input  wire logic [12:0] sample_code_i,
  output logic             conv_request_o,
  // interrupt
  output logic             irq_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic        left_adjust_select_r;     // control word a bit 0
  logic        diff_mode_r;              // control word a bit 1
  logic [2:0]  accumulation_count_select_r; // control word b, log2 of samples
  logic [1:0]  int_flags_r;              // sticky: ready, overrun
  logic [1:0]  int_mask_r;               // enables onto irq
  logic [18:0] acc_r;                    // running sum, wide for 128 samples
  logic [7:0]  count_r;                  // samples summed so far
  logic [1:0]  fmt_cnt_r;                // formatting delay counter
  arfa_state_e state_r;                  // sequence state
  logic [15:0] conversion_result_word;   // formatted result from formatter
  logic [11:0] clamp_code;               // clamped sample
  logic        clamp_valid;              // clamped sample valid
  logic        wr_en;                    // apb write access
  logic        rd_en;                    // apb read access
  logic        start_pulse;              // software start of a sequence
  logic        seq_done;                 // last formatting cycle
  logic        result_ready_flag_set;               // ready event
  logic        ovr_set;                  // sample arrived while not accumulating
  arfa_sample_s raw;                     // packed sample to clamp stage
  arfa_cfg_s    cfg;                     // packed config to formatter

  assign raw = '{valid: sample_valid_i, diff: diff_mode_r, code: sample_code_i};
  assign cfg = '{left_adjust_select: left_adjust_select_r, diff: diff_mode_r,
                 accumulation_count_select: accumulation_count_select_r};

  // single access phase: pready high during every access, zero wait states
  assign wr_en = psel_i & penable_i & pwrite_i;
  assign rd_en = psel_i & ~penable_i & ~pwrite_i;
  assign start_pulse = wr_en && (paddr_i == `ARFA_OFF_CTRL_C) && pwdata_i[`ARFA_START_BIT];

  // sign-extend (differential) or zero-extend (single-ended) a 12-bit code to the accumulator width
  function automatic logic [18:0] arfa_extend(input logic [11:0] c, input logic d);
    arfa_extend = d ? {{7{c[11]}}, c} : {7'h00, c};
  endfunction : arfa_extend

  // address is one of ours
  function automatic logic arfa_mapped(input logic [11:0] a);
    arfa_mapped = (a == `ARFA_OFF_CTRL_A) || (a == `ARFA_OFF_CTRL_B) ||
                  (a == `ARFA_OFF_CTRL_C) || (a == `ARFA_OFF_RESULT) ||
                  (a == `ARFA_OFF_INT_FLAGS) || (a == `ARFA_OFF_INT_MASK) ||
                  (a == `ARFA_OFF_STATUS);
  endfunction : arfa_mapped

  ////////////////////////////////////////////////////////////////////////////
  // sub-blocks
  arfa_clamp u_clamp (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .raw_i   (raw),
    .code_o  (clamp_code),
    .valid_o (clamp_valid)
  );

  arfa_format u_format (
    .mclk_i  (mclk_i),
    .rst_n_i (rst_n_i),
    .start_i (seq_done),
    .cfg_i   (cfg),
    .sum_i   (acc_r),
    .word_o  (conversion_result_word)
  );

  ////////////////////////////////////////////////////////////////////////////
  // configuration registers; changing them mid-sequence is software's hazard
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      left_adjust_select_r        <= 1'b0;
      diff_mode_r                 <= 1'b0;
      accumulation_count_select_r <= `ARFA_CTRL_B_RST;
    end
    else if (wr_en && paddr_i == `ARFA_OFF_CTRL_A)
    begin
      left_adjust_select_r <= pwdata_i[`ARFA_LEFT_ADJ_BIT];
      diff_mode_r          <= pwdata_i[`ARFA_DIFF_BIT];
    end
    else if (wr_en && paddr_i == `ARFA_OFF_CTRL_B)
      accumulation_count_select_r <= pwdata_i[`ARFA_ACC_LSB +: `ARFA_ACC_W];
  end

  ////////////////////////////////////////////////////////////////////////////
  // sequence control
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      state_r   <= ARFA_IDLE;
      acc_r     <= 19'h0_0000;
      count_r   <= 8'h00;
      fmt_cnt_r <= 2'h0;
    end
    else
    begin
      case (state_r)
        ARFA_IDLE:
        begin
          if (start_pulse)
          begin
            acc_r   <= 19'h0_0000;
            count_r <= 8'h00;
            state_r <= ARFA_ACCUM;
          end
        end
        ARFA_ACCUM:
        begin
          if (clamp_valid)
          begin
            acc_r   <= acc_r + arfa_extend(clamp_code, diff_mode_r);
            count_r <= count_r + 8'h01;
            if ((count_r + 8'h01) == (8'h01 << accumulation_count_select_r))
            begin
              fmt_cnt_r <= 2'h0;
              state_r   <= ARFA_FORMAT;
            end
          end
        end
        ARFA_FORMAT:
        begin
          fmt_cnt_r <= fmt_cnt_r + 2'h1;
          if (seq_done)
            state_r <= ARFA_IDLE;
        end
        default:
          state_r <= ARFA_IDLE;
      endcase
    end
  end

  assign seq_done = (state_r == ARFA_FORMAT) && (fmt_cnt_r == 2'(`ARFA_FORMAT_CYCLES - 1));

  ////////////////////////////////////////////////////////////////////////////
  // conversion request to the analog core, high while samples are wanted
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      conv_request_o <= 1'b0;
    else
      conv_request_o <= (state_r == ARFA_ACCUM) && !(clamp_valid &&
                        ((count_r + 8'h01) == (8'h01 << accumulation_count_select_r)));
  end

  ////////////////////////////////////////////////////////////////////////////
  // interrupt flags: set wins over a write-one clear in the same cycle
  assign result_ready_flag_set = seq_done;
  assign ovr_set    = clamp_valid && (state_r != ARFA_ACCUM);

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      int_flags_r <= 2'b00;
    else
    begin
      if (wr_en && paddr_i == `ARFA_OFF_INT_FLAGS)
        int_flags_r <= int_flags_r & ~pwdata_i[1:0] | {ovr_set, result_ready_flag_set};
      else
        int_flags_r <= int_flags_r | {ovr_set, result_ready_flag_set};
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      int_mask_r <= 2'b00;
    else if (wr_en && paddr_i == `ARFA_OFF_INT_MASK)
      int_mask_r <= pwdata_i[1:0];
  end

  // registered irq lags the flag by one cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
      irq_o <= 1'b0;
    else
      irq_o <= |(int_flags_r & int_mask_r);
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb answer: data registered in setup, ready on the access cycle
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      prdata_o  <= 32'h0000_0000;
      pready_o  <= 1'b0;
      pslverr_o <= 1'b0;
    end
    else
    begin
      pready_o  <= psel_i & ~penable_i;
      pslverr_o <= psel_i & ~penable_i & ~arfa_mapped(paddr_i);
      if (rd_en)
      begin
        case (paddr_i)
          `ARFA_OFF_CTRL_A:    prdata_o <= {30'h0, diff_mode_r, left_adjust_select_r};
          `ARFA_OFF_CTRL_B:    prdata_o <= {29'h0, accumulation_count_select_r};
          `ARFA_OFF_RESULT:    prdata_o <= {16'h0000, conversion_result_word};
          `ARFA_OFF_INT_FLAGS: prdata_o <= {30'h0, int_flags_r};
          `ARFA_OFF_INT_MASK:  prdata_o <= {30'h0, int_mask_r};
          `ARFA_OFF_STATUS:    prdata_o <= {30'h0, state_r};
          default:             prdata_o <= 32'h0000_0000;
        endcase
      end
    end
  end

endmodule : arfa_top

// [arfa_monitor.sv]
// concurrent checks on the formatter top ports
`timescale 1ns/100ps
`include "arfa_defines.svh"

module arfa_monitor (
  input wire logic        mclk_i,
  input wire logic        rst_n_i,
  input wire logic        psel_i,
  input wire logic        penable_i,
  input wire logic        pwrite_i,
  input wire logic [11:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic        pready_o,
  input wire logic        pslverr_o,
  input wire logic        sample_valid_i,
  input wire logic [12:0] sample_code_i,
  input wire logic        conv_request_o,
  input wire logic        irq_o
);
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  //////////////////////////////////////////////////////////////////////
  // apb answer: zero wait states, one cycle pulse
  a_ready_after_setup: assert property (psel_i && !penable_i |=> pready_o)
    else $error("pready missing after setup");
  a_ready_one_cycle: assert property (pready_o |=> !pready_o)
    else $error("pready held too long");
  a_ready_in_access: assert property (pready_o |-> psel_i && penable_i)
    else $error("pready outside access");
  a_err_with_ready: assert property (pslverr_o |-> pready_o)
    else $error("pslverr without pready");
  a_err_reads_zero: assert property (pslverr_o |-> prdata_o == 32'h0000_0000)
    else $error("error read not zero");
  a_unmapped_err: assert property (psel_i && !penable_i && paddr_i > 12'h018 |=> pslverr_o)
    else $error("unmapped address not refused");
  // masking everything drops the interrupt after one cycle lag
  a_mask_drops_irq: assert property (psel_i && penable_i && pwrite_i && paddr_i == `ARFA_OFF_INT_MASK
    && pwdata_i[1:0] == 2'h0 |-> ##2 !irq_o)
    else $error("irq stays with mask clear");
  // a start from idle raises the sample request two cycles after the access
  a_start_requests: assert property (psel_i && penable_i && pwrite_i && paddr_i == `ARFA_OFF_CTRL_C
    && pwdata_i[0] && !conv_request_o && !$past(conv_request_o) |-> ##2 conv_request_o)
    else $error("start gave no request");
  // pready_o, irq_o and conv_request_o are quiet while reset is held
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_i |=> !pready_o && !irq_o && !conv_request_o)
    else $error("output active in reset");

  c_irq_rise: cover property ($rose(irq_o));
  c_err_seen: cover property (pslverr_o);
  c_request: cover property ($rose(conv_request_o));
endmodule : arfa_monitor

bind arfa_top arfa_monitor arfa_monitor_inst (
  .mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel_i), .penable_i(penable_i),
  .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o),
  .pready_o(pready_o), .pslverr_o(pslverr_o), .sample_valid_i(sample_valid_i),
  .sample_code_i(sample_code_i), .conv_request_o(conv_request_o), .irq_o(irq_o)
);

// [arfa_core_model.sv]
// behavioural analog core: hands out samples while they are requested
`timescale 1ns/100ps

module arfa_core_model (
  input  wire logic        mclk_i,
  input  wire logic        rst_n_i,
  input  wire logic        conv_request_i,
  input  wire logic [12:0] code_i,
  input  wire logic [3:0]  gap_i,
  output logic             sample_valid_o,
  output logic [12:0]      sample_code_o
);
  logic [3:0] wait_r; // idle cycles left before next sample

  // one pulse per sample, gap_i idle cycles apart (0 = back to back)
  always_ff @(posedge mclk_i)
  begin
    if (!rst_n_i)
    begin
      sample_valid_o <= 1'b0;
      sample_code_o  <= 13'h0000;
      wait_r         <= 4'h0;
    end
    else if (conv_request_i && wait_r == 4'h0)
    begin
      sample_valid_o <= 1'b1;
      sample_code_o  <= code_i;
      wait_r         <= gap_i;
    end
    else
    begin
      // code not valid: show the inverse so a stale value never matches
      sample_valid_o <= 1'b0;
      sample_code_o  <= ~sample_code_o;
      wait_r         <= (wait_r != 4'h0) ? wait_r - 4'h1 : 4'h0;
    end
  end
endmodule : arfa_core_model

// [tb.sv]
// self-checking bench for the result formatter over apb
`timescale 1ns/100ps
`include "arfa_defines.svh"

module tb;
  import arfa_pkg::*;
  logic        mclk_i, rst_n_i, psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic        pready, pslverr, err, svalid, creq, irq;
  logic [12:0] scode, code;
  logic [3:0]  gap;
  int          failures, n_checks, k;
  logic [11:0] offs [5] = '{`ARFA_OFF_CTRL_A, `ARFA_OFF_CTRL_B, `ARFA_OFF_RESULT,
                            `ARFA_OFF_INT_FLAGS, `ARFA_OFF_INT_MASK};

  arfa_top arfa_top_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .psel_i(psel), .penable_i(penable),
    .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .sample_valid_i(svalid), .sample_code_i(scode), .conv_request_o(creq),
    .irq_o(irq));
  arfa_core_model arfa_core_model_inst (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .conv_request_i(creq),
    .code_i(code), .gap_i(gap), .sample_valid_o(svalid), .sample_code_o(scode));

  //////////////////////////////////////////////////////////////////////
  // 25 MHz clock
  initial
  begin
    mclk_i = 1'b0;
    forever #20 mclk_i = ~mclk_i;
  end

  task end_of_test;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : end_of_test

  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // one apb transfer; request held until pready is sampled
  task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk_i);
    psel <= 1'b1; penable <= 1'b0; pwrite <= wr; paddr <= a; pwdata <= d;
    @(posedge mclk_i);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge mclk_i);
      if (pready === 1'b1) break;
    end
    if (i == 20) begin failures++; end_of_test(); end
    rd = prdata; err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask : apb

  // expected word: clamp, sum of 2^n equal samples, truncate, adjust
  function logic [15:0] expw(input logic [12:0] c, input logic d, input logic la, input int n);
    int v;
    v = d ? int'($signed(c)) : ((c[12:11] == 2'b11) ? -1 : int'(c));
    if (d) v = (v > 2047) ? 2047 : (v < -2048) ? -2048 : v;
    else v = (v > 4095) ? 4095 : (v < 0) ? 0 : v;
    v = v * (1 << n);
    if (n > 4) v = v >>> (n - 4);
    if (la) v = v << (4 - ((n < 4) ? n : 4));
    return v[15:0];
  endfunction : expw

  // one sequence; m keeps the interrupt masked until the flag is polled
  task run(input logic m, input logic [12:0] c, input logic d, input logic la, input int n, input int g);
    int i;
    code <= c; gap <= g[3:0];
    apb(1'b1, `ARFA_OFF_CTRL_A, {30'h0, d, la});
    apb(1'b1, `ARFA_OFF_CTRL_B, n & 32'h0000_0007);
    apb(1'b1, `ARFA_OFF_CTRL_C, 32'h0000_0001);
    for (i = 0; i < 2000; i++)
    begin
      if (m) begin apb(1'b0, `ARFA_OFF_INT_FLAGS, 32'h0000_0000); if (rd[0] === 1'b1) break; end
      else begin @(posedge mclk_i); if (irq === 1'b1) break; end
    end
    if (i == 2000) begin failures++; end_of_test(); end
    if (m)
    begin
      chk(irq, 1'b0);
      apb(1'b1, `ARFA_OFF_INT_MASK, 32'h0000_0001);
      repeat (2) @(posedge mclk_i);
      chk(irq, 1'b1);
    end
    apb(1'b0, `ARFA_OFF_RESULT, 32'h0000_0000);
    chk(rd, {16'h0, expw(c, d, la, n)});
    apb(1'b1, `ARFA_OFF_INT_FLAGS, 32'h0000_0003);
    repeat (2) @(posedge mclk_i);
    chk(irq, 1'b0);
  endtask : run

  //////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    failures = 0; n_checks = 0; rst_n_i = 1'b0; psel = 1'b0; penable = 1'b0;
    pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0000_0000; code = 13'h0000; gap = 4'h0;
    repeat (5) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    foreach (offs[j])
    begin
      apb(1'b0, offs[j], 32'h0000_0000);
      chk(rd, 32'h0000_0000);
      chk(err, 1'b0);
    end
    apb(1'b0, 12'h0FC, 32'h0000_0000);
    chk(rd, 32'h0000_0000);
    chk(err, 1'b1);
    run(1'b1, 13'h0ABC, 1'b0, 1'b0, 0, 3);
    run(1'b0, 13'h1000, 1'b0, 1'b0, 0, 0);
    run(1'b0, 13'h1FFF, 1'b0, 1'b0, 0, 0);
    run(1'b0, 13'h0900, 1'b1, 1'b0, 0, 2);
    run(1'b0, 13'h1700, 1'b1, 1'b0, 0, 0);
    run(1'b0, 13'h1FFF, 1'b1, 1'b0, 0, 1);
    run(1'b0, 13'h0ABC, 1'b0, 1'b1, 0, 0);
    for (k = 0; k < 16; k++)
      run(1'b0, 13'h0F5A, 1'b0, k[3], k & 7, k & 3);
    for (k = 0; k < 16; k++)
      run(1'b0, 13'h1A5C, 1'b1, k[3], k & 7, k & 1);
    end_of_test();
  end
endmodule : tb
